// [logic/sdi_decoder.sv]
// Purpose: Decode configurable digital inputs into drive control actions
// Assumes: Parameters and speeds come from the drive core on the same clock
// Notes:   Each input has a 5-bit function code; several inputs may share one
// Operation
// RULE1 - Closed contact is ON, open contact is OFF
// RULE2 - Enable input ON enables the servo motor
// RULE3 - Alarm clear removes only the eight clearable alarm codes
// RULE4 - Counterclockwise limit raises travel alarm unless limits are disabled
// RULE5 - Clockwise limit behaves the same as counterclockwise limit
// RULE6 - In position mode deviation clear zeroes the deviation counter
// RULE7 - In position mode pulse inhibit stops command pulse counting
// RULE8 - While pulses are inhibited the servo holds position lock
// RULE9 - Speed mode clamp input with small command stops and locks motor
// RULE10 - Clamp is left only above threshold plus hysteresis
// RULE11 - Direction source 0: reverse input chooses set or reversed direction
// RULE12 - Direction source 1: two direction select inputs set direction
// RULE13 - Emergency stop input stops driving the motor
// RULE14 - Homing launch input requests start of homing
// RULE15 - Internal position start input launches selected position run
// RULE16 - Homing launch works only when startup mode is 2
// RULE17 - Origin input is homing reference when reference setting selects it
// RULE18 - Each input is synchronised and debounced before decoding
`timescale 1ns/1ps
`default_nettype none
module sdi_decoder #(
   parameter int unsigned NUM_DI          = sdi_pkg::NUM_DI,
   parameter int unsigned SPEED_W         = sdi_pkg::SPEED_W,
   parameter int unsigned DEBOUNCE_CYCLES = sdi_pkg::DEBOUNCE_CYCLES
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 reset,
   // Contact inputs, high when closed
   input  wire logic [NUM_DI-1:0]    di_raw,
   // Configuration
   input  wire logic [5*NUM_DI-1:0]  di_function,
   input  wire logic [1:0]           control_mode,
   input  wire logic                 limit_disable,
   input  wire logic                 direction_source,
   input  wire logic [1:0]           homing_start_mode,
   input  wire logic [1:0]           homing_reference,
   input  wire logic [SPEED_W-1:0]   clamp_threshold,
   input  wire logic [SPEED_W-1:0]   clamp_hysteresis,
   // Drive state
   input  wire logic [SPEED_W-1:0]   speed_command_mag,
   input  wire logic [SPEED_W-1:0]   motor_speed_mag,
   input  wire logic                 alarm_set_valid,
   input  wire logic [4:0]           alarm_set_code,
   // Actions
   output logic                      motor_enable,
   output logic                      drive_stop,
   output logic [31:0]               alarm_latched,
   output logic                      deviation_clear,
   output logic                      pulse_count_inhibit,
   output logic                      servo_lock,
   output logic                      zero_clamp_active,
   output logic                      speed_reversed,
   output logic [1:0]                direction_select,
   output logic                      homing_request,
   output logic                      homing_reference_hit,
   output logic                      homing_search_ccw,
   output logic                      position_run_start,
   output logic [NUM_DI-1:0]         di_state
);
   logic [NUM_DI-1:0] di_on;
   logic [31:0]       fn_on;
   logic              home_q;
   logic              start_q;

   function automatic logic [31:0] fn_onehot(input logic [4:0] code);
      fn_onehot = 32'h0000_0000;
      fn_onehot[code] = 1'b1;
   endfunction : fn_onehot

   // Input conditioning
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DI; gi++) begin : g_di
         sdi_filter #(.CYCLES(DEBOUNCE_CYCLES)) u_filt (
            .clock (clock),
            .reset (reset),
            .raw   (di_raw[gi]), // RULE1
            .level (di_on[gi])   // RULE18
         );
      end
   endgenerate

   always_comb begin
      fn_on = 32'h0000_0000;
      for (int i = 0; i < NUM_DI; i++) begin
         if (di_on[i]) begin
            fn_on = fn_on | fn_onehot(di_function[5*i +: 5]);
         end
      end
      fn_on[sdi_pkg::FN_NONE] = 1'b0;
   end

   wire logic pos_mode = control_mode == sdi_pkg::MODE_POSITION;
   wire logic spd_mode = control_mode == sdi_pkg::MODE_SPEED;
   wire logic lim_hit  = !limit_disable
                         && (fn_on[sdi_pkg::FN_CCWLIM] || fn_on[sdi_pkg::FN_CWLIM]); // RULE4 RULE5

   // Enable and stop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         motor_enable <= 1'b0;
         drive_stop   <= 1'b0;
         di_state     <= '0;
      end else begin
         drive_stop   <= fn_on[sdi_pkg::FN_ESTOP]; // RULE13
         motor_enable <= fn_on[sdi_pkg::FN_ENABLE] && !fn_on[sdi_pkg::FN_ESTOP]; // RULE2 RULE13
         di_state     <= di_on;
      end
   end

   // Alarm latch; a new alarm wins over a clear in the same cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         alarm_latched <= 32'h0000_0000;
      end else begin
         alarm_latched <= (fn_on[sdi_pkg::FN_ALMCLR]
                           ? alarm_latched & ~sdi_pkg::ALARM_CLEARABLE // RULE3
                           : alarm_latched)
                          | (alarm_set_valid ? fn_onehot(alarm_set_code) : 32'h0000_0000)
                          | (lim_hit ? fn_onehot(5'(sdi_pkg::ALARM_TRAVEL))
                                     : 32'h0000_0000); // RULE4 RULE5
      end
   end

   // Position mode actions
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         deviation_clear     <= 1'b0;
         pulse_count_inhibit <= 1'b0;
      end else begin
         deviation_clear     <= pos_mode && fn_on[sdi_pkg::FN_DEVCLR]; // RULE6
         pulse_count_inhibit <= pos_mode && fn_on[sdi_pkg::FN_INHIBIT]; // RULE7
      end
   end

   // Zero speed clamp with hysteresis
   wire logic [SPEED_W:0] exit_level = {1'b0, clamp_threshold} + {1'b0, clamp_hysteresis};
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         zero_clamp_active <= 1'b0;
      end else if (!(spd_mode && fn_on[sdi_pkg::FN_CLAMP])) begin
         zero_clamp_active <= 1'b0;
      end else if (!zero_clamp_active) begin
         zero_clamp_active <= speed_command_mag < clamp_threshold; // RULE9
      end else if ({1'b0, motor_speed_mag} > exit_level) begin
         zero_clamp_active <= 1'b0; // RULE10
      end
   end

   always_comb begin
      servo_lock = pulse_count_inhibit || zero_clamp_active; // RULE8 RULE9
   end

   // Direction
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         speed_reversed   <= 1'b0;
         direction_select <= 2'h0;
      end else if (!direction_source) begin
         speed_reversed   <= fn_on[sdi_pkg::FN_REVERSE]; // RULE11
         direction_select <= 2'h0;
      end else begin
         speed_reversed   <= 1'b0;
         direction_select <= {fn_on[sdi_pkg::FN_DIRB], fn_on[sdi_pkg::FN_DIRA]}; // RULE12
      end
   end

   // Homing and position run launches, one pulse per rising input
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         home_q             <= 1'b0;
         start_q            <= 1'b0;
         homing_request     <= 1'b0;
         position_run_start <= 1'b0;
      end else begin
         home_q             <= fn_on[sdi_pkg::FN_HOME];
         start_q            <= fn_on[sdi_pkg::FN_POSSTART];
         homing_request     <= fn_on[sdi_pkg::FN_HOME] && !home_q
                               && homing_start_mode == sdi_pkg::HOME_BY_IN; // RULE14 RULE16
         position_run_start <= fn_on[sdi_pkg::FN_POSSTART] && !start_q; // RULE15
      end
   end

   // Homing reference point
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         homing_reference_hit <= 1'b0;
         homing_search_ccw    <= 1'b0;
      end else begin
         homing_search_ccw    <= homing_reference[0]; // RULE17
         case (homing_reference)
            2'h0:                   homing_reference_hit <= fn_on[sdi_pkg::FN_CCWLIM];
            2'h1:                   homing_reference_hit <= fn_on[sdi_pkg::FN_CWLIM];
            sdi_pkg::HREF_ORG_CW,
            sdi_pkg::HREF_ORG_CCW:  homing_reference_hit <= fn_on[sdi_pkg::FN_ORIGIN]; // RULE17
            default:                homing_reference_hit <= 1'b0;
         endcase
      end
   end

   // Checks
   property clamp_exit_p;
      @(posedge clock) disable iff (reset)
      zero_clamp_active && spd_mode && fn_on[sdi_pkg::FN_CLAMP]
         && {1'b0, motor_speed_mag} <= exit_level |=> zero_clamp_active;
   endproperty
   clamp_hold_a: assert property (clamp_exit_p) else $error("clamp left too early"); // RULE10
   estop_a: assert property (@(posedge clock) disable iff (reset) // RULE13
      fn_on[sdi_pkg::FN_ESTOP] |=> drive_stop && !motor_enable) else $error("estop ignored");
   enable_a: assert property (@(posedge clock) disable iff (reset) // RULE2
      fn_on[sdi_pkg::FN_ENABLE] && !fn_on[sdi_pkg::FN_ESTOP] |=> motor_enable)
      else $error("enable missed");
   travel_alarm_a: assert property (@(posedge clock) disable iff (reset) // RULE4
      lim_hit |=> alarm_latched[sdi_pkg::ALARM_TRAVEL]) else $error("travel alarm missing");
   limit_off_a: assert property (@(posedge clock) disable iff (reset) // RULE5
      limit_disable && !alarm_set_valid && !alarm_latched[sdi_pkg::ALARM_TRAVEL]
      |=> !alarm_latched[sdi_pkg::ALARM_TRAVEL]) else $error("disabled limit alarmed");
   alarm_keep_a: assert property (@(posedge clock) disable iff (reset) // RULE3
      fn_on[sdi_pkg::FN_ALMCLR] |=> ((alarm_latched ^ $past(alarm_latched))
      & $past(alarm_latched) & ~sdi_pkg::ALARM_CLEARABLE) == 32'h0000_0000)
      else $error("fixed alarm lost");
   inhibit_lock_a: assert property (@(posedge clock) disable iff (reset) // RULE7
      pos_mode && fn_on[sdi_pkg::FN_INHIBIT] |=> pulse_count_inhibit && servo_lock)
      else $error("inhibit lock missing");
   devclr_a: assert property (@(posedge clock) disable iff (reset) // RULE6
      deviation_clear |-> $past(pos_mode)) else $error("clear outside position mode");
   home_mode_a: assert property (@(posedge clock) disable iff (reset) // RULE16
      homing_request |-> $past(homing_start_mode) == sdi_pkg::HOME_BY_IN)
      else $error("homing in wrong mode");
   reverse_a: assert property (@(posedge clock) disable iff (reset) // RULE11
      !direction_source |=> speed_reversed == $past(fn_on[sdi_pkg::FN_REVERSE]))
      else $error("reverse wrong");
endmodule : sdi_decoder
`default_nettype wire

// [logic/sdi_pkg.sv]
// Purpose: Constants for the servo digital input decoder
// Assumes: 20 MHz control clock
// Notes:   Function codes are the assignment values of a configurable input
package sdi_pkg;
   localparam int unsigned CLK_HZ          = 20000000;
   localparam int unsigned DEBOUNCE_US     = 1000;
   localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1000000);
   localparam int unsigned NUM_DI          = 8;
   localparam int unsigned SPEED_W         = 16;
   // Input function assignment codes
   localparam logic [4:0] FN_NONE     = 5'h00;
   localparam logic [4:0] FN_ENABLE   = 5'h01;
   localparam logic [4:0] FN_ALMCLR   = 5'h02;
   localparam logic [4:0] FN_CCWLIM   = 5'h03;
   localparam logic [4:0] FN_CWLIM    = 5'h04;
   localparam logic [4:0] FN_DEVCLR   = 5'h05;
   localparam logic [4:0] FN_INHIBIT  = 5'h06;
   localparam logic [4:0] FN_CLAMP    = 5'h07;
   localparam logic [4:0] FN_DIRA     = 5'h08;
   localparam logic [4:0] FN_DIRB     = 5'h09;
   localparam logic [4:0] FN_REVERSE  = 5'h17;
   localparam logic [4:0] FN_ESTOP    = 5'h18;
   localparam logic [4:0] FN_HOME     = 5'h19;
   localparam logic [4:0] FN_ORIGIN   = 5'h1a;
   localparam logic [4:0] FN_POSSTART = 5'h1b;
   // Homing startup mode
   localparam logic [1:0] HOME_OFF    = 2'h0;
   localparam logic [1:0] HOME_AUTO   = 2'h1;
   localparam logic [1:0] HOME_BY_IN  = 2'h2;
   // Homing reference selections using the origin input
   localparam logic [1:0] HREF_ORG_CW  = 2'h2;
   localparam logic [1:0] HREF_ORG_CCW = 2'h3;
   // Clearable alarm code bits
   localparam logic [31:0] ALARM_CLEARABLE = 32'h0105_c380;
   localparam int unsigned ALARM_TRAVEL    = 15;
   // Control modes
   localparam logic [1:0] MODE_POSITION = 2'h0;
   localparam logic [1:0] MODE_SPEED    = 2'h1;
endpackage : sdi_pkg

// [logic/sdi_filter.sv]
// Purpose: Synchronise and debounce one contact input
// Assumes: Contact closed drives raw high
// Notes:   Output changes only after a stable run of the set length
`timescale 1ns/1ps
`default_nettype none
module sdi_filter #(
   parameter int unsigned CYCLES = sdi_pkg::DEBOUNCE_CYCLES
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Contact
   input  wire logic raw,
   output logic      level
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   logic          s1_q;
   logic          s2_q;
   logic [CW-1:0] cnt_q;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cnt_q <= '0;
         level <= 1'b0;
      end else if (s2_q == level) begin
         cnt_q <= '0;
      end else if (cnt_q == CW'(CYCLES - 1)) begin
         cnt_q <= '0;
         level <= s2_q; // RULE18
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule : sdi_filter
`default_nettype wire

// [verification/sdi_contacts.sv]
// Purpose: Contact model driving the raw digital inputs
// Assumes: A closed contact reads high, an open one low
// Notes:   Each change bounces for a few cycles before it settles
`timescale 1ns/1ps
`default_nettype none
module sdi_contacts (
   // Clock
   input  wire logic       clock,
   // Wanted contact states, 1 = closed
   input  wire logic [7:0] closed,
   // Contact lines
   output logic      [7:0] di_raw
);
   logic [7:0] raw_q = 8'h00;
   logic [7:0] chg_q = 8'h00;
   logic [1:0] cnt_q = 2'h0;
   assign di_raw = raw_q;
   // Bounce on change, runs shorter than the filter length
   always @(posedge clock) begin
      if (cnt_q == 2'h0 && closed != raw_q) begin
         chg_q <= closed ^ raw_q;
         raw_q <= closed;
         cnt_q <= 2'h3;
      end else if (cnt_q > 2'h1) begin
         raw_q <= raw_q ^ chg_q;
         cnt_q <= cnt_q - 2'h1;
      end else begin
         raw_q <= closed;
         cnt_q <= 2'h0;
      end
   end
endmodule : sdi_contacts
`default_nettype wire

// [verification/sdi_decoder_tb.sv]
// Purpose: Self-checking bench for the digital input decoder
// Assumes: Filter length set to 4 cycles
// Notes:   Each input change is given 20 cycles to settle
`timescale 1ns/1ps
`default_nettype none
module sdi_decoder_tb;
   logic clock = 1'b0, reset = 1'b1, ld = 1'b0, dsrc = 1'b0, aval = 1'b0;
   logic [7:0] closed = 8'h00, di_raw, dst;
   logic [39:0] fn = 40'h0;
   logic [1:0] mode = 2'h0, hmode = 2'h0, href = 2'h0, dsel;
   logic [4:0] acode = 5'h00;
   logic [15:0] thr = 16'h0, hys = 16'h0, cmd = 16'h0, mspd = 16'h0;
   logic men, dstop, devc, inh, lock, zc, rev, hreq, hhit, hccw, prun;
   logic [31:0] alm, m;
   int error_cnt = 0, comparisons = 0, hcnt = 0, pcnt = 0, c0;
   sdi_contacts sdi_contacts_i (.clock(clock), .closed(closed), .di_raw(di_raw));
   sdi_decoder #(.DEBOUNCE_CYCLES(4)) sdi_decoder_i (.clock(clock), .reset(reset),
      .di_raw(di_raw), .di_function(fn), .control_mode(mode), .limit_disable(ld),
      .direction_source(dsrc), .homing_start_mode(hmode), .homing_reference(href),
      .clamp_threshold(thr), .clamp_hysteresis(hys), .speed_command_mag(cmd),
      .motor_speed_mag(mspd), .alarm_set_valid(aval), .alarm_set_code(acode),
      .motor_enable(men), .drive_stop(dstop), .alarm_latched(alm), .deviation_clear(devc),
      .pulse_count_inhibit(inh), .servo_lock(lock), .zero_clamp_active(zc),
      .speed_reversed(rev), .direction_select(dsel), .homing_request(hreq),
      .homing_reference_hit(hhit), .homing_search_ccw(hccw), .position_run_start(prun),
      .di_state(dst));
   always #25 clock = ~clock;
   always @(posedge clock) begin
      if (hreq === 1'b1) hcnt++;
      if (prun === 1'b1) pcnt++;
   end
   function automatic logic [31:0] clr_mask();
      clr_mask = 32'h0;
      foreach (m[b]) clr_mask[b] = (b inside {7, 8, 9, 14, 15, 16, 18, 24});
   endfunction : clr_mask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : step
   task automatic put(input int i, input logic [4:0] c, input logic v);
      fn[5*i +: 5] = c;
      closed[i] = v;
      step(20);
   endtask : put
   task automatic results();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   initial begin
      #(50 * 4000);
      error_cnt++;
      results();
   end
   initial begin
      void'($urandom(32'hc207));
      step(6);
      reset = 1'b0;
      step(1);
      chk("idle", 32'({men, dstop, hreq, prun, zc}), 32'h0000_0000);
      chk("idle alarms", alm, 32'h0000_0000);
      put(0, sdi_pkg::FN_ENABLE, 1'b1);
      chk("enable", 32'({men, dst}), 32'h0000_0101);
      put(1, sdi_pkg::FN_ESTOP, 1'b1);
      chk("estop", 32'({men, dstop}), 32'h0000_0001);
      put(1, sdi_pkg::FN_ESTOP, 1'b0);
      for (int c = 0; c < 32; c++) begin
         aval = 1'b1;
         acode = c[4:0];
         step(1);
      end
      aval = 1'b0;
      put(2, sdi_pkg::FN_ALMCLR, 1'b1);
      chk("alarm clear", alm, ~clr_mask());
      put(2, sdi_pkg::FN_ALMCLR, 1'b0);
      for (int k = 0; k < 4; k++) begin
         ld = k[0];
         put(3, k[1] ? sdi_pkg::FN_CWLIM : sdi_pkg::FN_CCWLIM, 1'b1);
         chk("limit", 32'(alm[sdi_pkg::ALARM_TRAVEL]), 32'(!ld));
         put(3, sdi_pkg::FN_NONE, 1'b0);
         put(2, sdi_pkg::FN_ALMCLR, 1'b1);
         put(2, sdi_pkg::FN_ALMCLR, 1'b0);
      end
      for (int k = 0; k < 2; k++) begin
         mode = k[0] ? sdi_pkg::MODE_SPEED : sdi_pkg::MODE_POSITION;
         put(4, sdi_pkg::FN_DEVCLR, 1'b1);
         put(5, sdi_pkg::FN_INHIBIT, 1'b1);
         chk("devclr", 32'(devc), 32'(!k[0]));
         chk("inhibit", 32'({inh, lock}), k[0] ? 32'h0000_0000 : 32'h0000_0003);
         put(4, sdi_pkg::FN_NONE, 1'b0);
         put(5, sdi_pkg::FN_NONE, 1'b0);
      end
      repeat (3) begin
         thr = 16'($urandom_range(1000, 10));
         hys = 16'($urandom_range(50, 1));
         cmd = thr - 16'h1;
         put(6, sdi_pkg::FN_CLAMP, 1'b1);
         chk("clamp", 32'({zc, lock}), 32'h0000_0003);
         cmd = thr;
         mspd = thr + hys;
         step(5);
         chk("clamp hold", 32'(zc), 32'h0000_0001);
         mspd = thr + hys + 16'h1;
         step(5);
         chk("clamp leave", 32'(zc), 32'h0000_0000);
         put(6, sdi_pkg::FN_NONE, 1'b0);
         mspd = 16'h0;
      end
      put(7, sdi_pkg::FN_REVERSE, 1'b1);
      chk("reverse", 32'(rev), 32'h0000_0001);
      put(7, sdi_pkg::FN_REVERSE, 1'b0);
      chk("forward", 32'(rev), 32'h0000_0000);
      dsrc = 1'b1;
      repeat (4) begin
         m = $urandom;
         put(0, sdi_pkg::FN_DIRA, m[0]);
         put(1, sdi_pkg::FN_DIRB, m[1]);
         chk("dirsel", 32'(dsel), 32'(m[1:0]));
      end
      put(0, sdi_pkg::FN_NONE, 1'b0);
      put(1, sdi_pkg::FN_NONE, 1'b0);
      for (int k = 0; k < 3; k++) begin
         hmode = k[1:0];
         c0 = hcnt;
         put(2, sdi_pkg::FN_HOME, 1'b1);
         chk("homing", 32'(hcnt - c0), 32'(k == 2));
         put(2, sdi_pkg::FN_HOME, 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         href = k[1:0];
         put(3, sdi_pkg::FN_ORIGIN, 1'b1);
         chk("origin", 32'({hhit, hccw}), 32'({k[1], k[0]}));
         put(3, sdi_pkg::FN_ORIGIN, 1'b0);
      end
      c0 = pcnt;
      put(4, sdi_pkg::FN_POSSTART, 1'b1);
      chk("run start", 32'(pcnt - c0), 32'h1);
      put(4, sdi_pkg::FN_POSSTART, 1'b0);
      results();
   end
endmodule : sdi_decoder_tb
`default_nettype wire
